// ==== design/ccpc_pkg.sv ====
package ccpc_pkg;

    // ==========================================================
    // Register map
    localparam logic [15:0] CCPC_ADDR_CLOCK_SETUP = 16'h4000;
    localparam logic [15:0] CCPC_ADDR_LEVEL = 16'h4001;
    localparam logic [15:0] CCPC_ADDR_SYNTH = 16'h4002;
    localparam logic [2:0] CCPC_SYNTH_LAST = 3'h5;      // Index of the sixth byte
    localparam logic [7:0] CCPC_CLOCK_SETUP_MASK = 8'h7f;
    localparam logic [7:0] CCPC_LEVEL_MASK = 8'h06;
    localparam logic [7:0] CCPC_READ_ZERO = 8'h00;

    // ==========================================================
    // Field layouts
    typedef struct packed {
        logic rsvd;
        logic [1:0] master_clock_output_pin_freq;
        logic master_clock_output_pin_en;
        logic src_pll;
        logic [1:0] in_freq;
        logic core_en;
    } ccpc_clock_setup_t;

    typedef struct packed {
        logic [4:0] rsvd_hi;
        logic [1:0] level;
        logic rsvd_lo;
    } ccpc_level_t;

    typedef struct packed {
        logic [15:0] denom;
        logic [15:0] numer;
        logic rsvd15;
        logic [3:0] integ;
        logic [1:0] prediv;
        logic frac;
        logic [5:0] rsvd;
        logic lock;
        logic enable;
    } ccpc_synth_t;

    // ==========================================================
    // Reset values
    localparam ccpc_clock_setup_t CCPC_CLOCK_SETUP_RST = 8'h00;
    localparam ccpc_level_t CCPC_LEVEL_RST = 8'h02;       // 1.4 V
    localparam ccpc_synth_t CCPC_SYNTH_RST = 48'h0753_0287_1900;

    // ==========================================================
    // Encodings
    localparam logic [1:0] CCPC_LEVEL_1V5 = 2'h0;
    localparam logic [1:0] CCPC_LEVEL_1V4 = 2'h1;
    localparam logic [1:0] CCPC_LEVEL_1V6 = 2'h2;
    localparam logic [1:0] CCPC_LEVEL_1V7 = 2'h3;
    localparam logic [1:0] CCPC_MASTER_CLOCK_OUTPUT_PIN_32X = 2'h0;
    localparam logic [1:0] CCPC_MASTER_CLOCK_OUTPUT_PIN_64X = 2'h1;
    localparam logic [1:0] CCPC_MASTER_CLOCK_OUTPUT_PIN_128X = 2'h2;
    localparam logic [1:0] CCPC_PREDIV_NONE = 2'h0;
    localparam logic [1:0] CCPC_PREDIV_3 = 2'h3;
    localparam logic [1:0] CCPC_DIV_BY_1 = 2'h1;
    localparam logic [1:0] CCPC_DIV_BY_2 = 2'h2;
    localparam logic [1:0] CCPC_DIV_BY_3 = 2'h3;

    // ==========================================================
    // Lock detector
    localparam logic [5:0] CCPC_LOCK_WINDOW = 6'h3f;    // Last reference tick count of a window; a window spans 64 ticks
    localparam logic signed [7:0] CCPC_LOCK_TOL = 8'sh01;

    typedef enum logic {
        CCPC_GATE_OFF = 1'b0,
        CCPC_GATE_RUN = 1'b1
    } ccpc_gate_t;

    typedef enum logic {
        CCPC_BURST_IDLE = 1'b0,
        CCPC_BURST_CAPTURE = 1'b1
    } ccpc_burst_t;

endpackage

// ==== design/ccpc_edge_div.sv ====
`timescale 1ns/1ps
module ccpc_edge_div import ccpc_pkg::*; #(
    parameter int W = 3
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic clear_in,
    input wire logic edge_in,
    input wire logic [W-1:0] div_in,
    output logic tick_out
);

    logic [W-1:0] count;
    logic [W-1:0] next_count;
    wire logic at_end;

    // A tick is the div-th edge; the count never exceeds div-1 while div holds
    assign at_end = (count >= (div_in - W'(1)));
    assign tick_out = edge_in && at_end;
    assign next_count = clear_in ? '0 : (!edge_in ? count : (at_end ? '0 : count + W'(1)));

    // ==========================================================
    // Edge counter
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

endmodule

// ==== design/ccpc_top.sv ====
// Operation
// - Output pin at 32/64/128/256 fs per field
// - Output pin driven only when enabled
// - Source bit: 0 input pin, 1 PLL
// - Divide source by 1-4 to 256 fs
// - Core clock runs only when enabled, default off
// - Regulator 1.4 V after init, software sets 1.5
// - Level codes 1.5/1.4/1.6/1.7 V, default 01
// - PLL parameters accepted only as six-byte burst
// - Denominator from bytes 47:40 and 39:32
// - Numerator from bytes 31:24 and 23:16
// - Prescaler divides reference before the PLL
// - Prescaler codes: 1, 2, 2, 3
// - Type bit at position 8 selects mode
// - Feedback divides by integer plus N/M
// - Sticky lock at bit 1, enable bit 0
`timescale 1ns/1ps
module ccpc_top import ccpc_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic cp_frame_in,
    input wire logic cp_wr_in,
    input wire logic cp_rd_in,
    input wire logic [15:0] cp_addr_in,
    input wire logic [7:0] cp_wdata_in,
    output logic [7:0] cp_rdata_out,
    output logic cp_rvalid_out,
    input wire logic master_clock_input_pin_in,
    input wire logic pll_vco_in,
    output logic sys_clock_out,
    output logic master_clock_output_pin_out,
    output logic master_clock_output_pin_oe_out,
    output logic [1:0] core_supply_output_level_out,
    output logic pll_enable_out,
    output logic pll_ref_tick_out,
    output logic pll_fb_tick_out
);

    // ==========================================================
    // Registers
    ccpc_clock_setup_t clock_setup;
    ccpc_level_t core_regulator_level;
    ccpc_synth_t synth_parameters;
    logic pll_locked;
    ccpc_burst_t burst_state;
    logic [2:0] burst_idx;
    logic [7:0] shadow [0:4];
    logic [7:0] rdata;
    logic rvalid;

    // ==========================================================
    // Pin synchronisers: stage 1 feeds stage 2 only
    logic [2:0] mclk_sync;
    logic [2:0] vco_sync;
    wire logic mclk_rise;
    wire logic mclk_any;
    wire logic vco_rise;
    wire logic vco_any;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mclk_sync <= 3'h0;
            vco_sync <= 3'h0;
        end else begin
            mclk_sync <= {mclk_sync[1:0], master_clock_input_pin_in};
            vco_sync <= {vco_sync[1:0], pll_vco_in};
        end
    end

    assign mclk_rise = mclk_sync[1] && !mclk_sync[2];
    assign mclk_any = mclk_sync[1] ^ mclk_sync[2];
    assign vco_rise = vco_sync[1] && !vco_sync[2];
    assign vco_any = vco_sync[1] ^ vco_sync[2];

    // ==========================================================
    // Control port decode
    wire logic wr_setup;
    wire logic wr_level;
    wire logic wr_synth_first;
    wire logic wr_synth_next;
    wire logic burst_abort;
    wire logic synth_commit;
    wire logic [15:0] synth_next_addr;
    wire logic [15:0] rd_offset;
    ccpc_synth_t synth_view;
    ccpc_synth_t synth_written;
    ccpc_clock_setup_t setup_written;

    assign wr_setup = cp_wr_in && (cp_addr_in == CCPC_ADDR_CLOCK_SETUP);
    assign setup_written = cp_wdata_in & CCPC_CLOCK_SETUP_MASK;
    assign wr_level = cp_wr_in && (cp_addr_in == CCPC_ADDR_LEVEL);
    assign synth_next_addr = CCPC_ADDR_SYNTH + {13'h0, burst_idx};
    assign wr_synth_first = cp_wr_in && (cp_addr_in == CCPC_ADDR_SYNTH);
    // Any stray access or end of frame drops a partial burst
    assign wr_synth_next = (burst_state == CCPC_BURST_CAPTURE) && cp_wr_in
        && (cp_addr_in == synth_next_addr) && !wr_synth_first;
    assign burst_abort = (burst_state == CCPC_BURST_CAPTURE) && !wr_synth_next
        && (!cp_frame_in || cp_wr_in || cp_rd_in);
    assign synth_commit = wr_synth_next && (burst_idx == CCPC_SYNTH_LAST);
    // Byte 0 lands in 47:40, so denominator then numerator fall out MSB first
    assign synth_written = {shadow[0], shadow[1], shadow[2], shadow[3], shadow[4], cp_wdata_in};

    // Control port state
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            clock_setup <= CCPC_CLOCK_SETUP_RST;
            core_regulator_level <= CCPC_LEVEL_RST;
            synth_parameters <= CCPC_SYNTH_RST;
            burst_state <= CCPC_BURST_IDLE;
            burst_idx <= 3'h0;
        end else begin
            if (wr_setup) begin
                clock_setup <= setup_written;
            end
            if (wr_level) begin
                core_regulator_level <= cp_wdata_in & CCPC_LEVEL_MASK;
            end
            if (synth_commit) begin
                synth_parameters <= synth_written;
            end
            if (wr_synth_first) begin
                burst_state <= CCPC_BURST_CAPTURE;
                burst_idx <= 3'h1;
            end else if (synth_commit || burst_abort) begin
                burst_state <= CCPC_BURST_IDLE;
                burst_idx <= 3'h0;
            end else if (wr_synth_next) begin
                burst_idx <= burst_idx + 3'h1;
            end
        end
    end

    // Shadow bytes of a burst in flight; only a full burst reaches the live copy
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < 5; i++) begin
                shadow[i] <= 8'h00;
            end
        end else if (wr_synth_first) begin
            shadow[0] <= cp_wdata_in;
        end else if (wr_synth_next && !synth_commit) begin
            shadow[burst_idx] <= cp_wdata_in;
        end
    end

    // ==========================================================
    // Read-back: lock reads from the detector, not from the stored byte
    wire logic [7:0] rd_mux;

    always_comb begin
        synth_view = synth_parameters;
        synth_view.lock = pll_locked;
    end

    assign rd_offset = cp_addr_in - CCPC_ADDR_SYNTH;
    assign rd_mux = (cp_addr_in == CCPC_ADDR_CLOCK_SETUP) ? clock_setup
        : (cp_addr_in == CCPC_ADDR_LEVEL) ? core_regulator_level
        : (cp_addr_in >= CCPC_ADDR_SYNTH && rd_offset <= {13'h0, CCPC_SYNTH_LAST})
        ? synth_view[8'(47 - 8 * rd_offset[2:0]) -: 8] : CCPC_READ_ZERO;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rvalid <= cp_rd_in;
            if (cp_rd_in) begin
                rdata <= rd_mux;
            end
        end
    end

    // ==========================================================
    // PLL reference prescaler and fractional feedback divider
    wire logic pll_en;
    wire logic [1:0] prediv;
    wire logic ref_tick;
    wire logic fb_tick;
    wire logic frac_mode;
    wire logic [16:0] acc_sum;
    wire logic acc_wrap;
    logic [15:0] nco_acc;
    logic [4:0] fb_mod;

    assign pll_en = synth_parameters.enable;
    // Codes 01 and 10 both divide by two
    assign prediv = (synth_parameters.prediv == CCPC_PREDIV_NONE) ? CCPC_DIV_BY_1
        : (synth_parameters.prediv == CCPC_PREDIV_3) ? CCPC_DIV_BY_3 : CCPC_DIV_BY_2;

    ccpc_edge_div #(.W(2)) u_prediv (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .clear_in(!pll_en),
        .edge_in(mclk_rise),
        .div_in(prediv),
        .tick_out(ref_tick)
    );

    ccpc_edge_div #(.W(5)) u_fbdiv (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .clear_in(!pll_en),
        .edge_in(vco_rise),
        .div_in(fb_mod),
        .tick_out(fb_tick)
    );

    // A zero denominator has no fraction to spread, so it runs integer-N
    assign frac_mode = synth_parameters.frac && (synth_parameters.denom != 16'h0000);
    assign acc_sum = {1'b0, nco_acc} + {1'b0, synth_parameters.numer};
    assign acc_wrap = frac_mode && (acc_sum >= {1'b0, synth_parameters.denom});

    // Each feedback period picks R or R+1 so the mean modulus is R + N/M
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            nco_acc <= 16'h0000;
            fb_mod <= 5'h03;
        end else if (!pll_en) begin
            nco_acc <= 16'h0000;
            fb_mod <= {1'b0, synth_parameters.integ};
        end else if (fb_tick) begin
            nco_acc <= !frac_mode ? 16'h0000
                : (acc_wrap ? 16'(acc_sum - {1'b0, synth_parameters.denom}) : acc_sum[15:0]);
            fb_mod <= {1'b0, synth_parameters.integ} + {4'h0, acc_wrap};
        end
    end

    // ==========================================================
    // Lock detector: error within tolerance for a whole window
    logic signed [7:0] phase_err;
    logic [5:0] win_count;
    logic win_bad;
    wire logic signed [7:0] next_phase_err;
    wire logic lock_set;
    wire logic lock_clear;

    assign next_phase_err = phase_err + (ref_tick ? 8'sh01 : 8'sh00) - (fb_tick ? 8'sh01 : 8'sh00);
    assign lock_set = pll_en && ref_tick && (win_count == CCPC_LOCK_WINDOW) && !win_bad;
    assign lock_clear = !pll_en || synth_commit;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            phase_err <= 8'sh00;
            win_count <= 6'h00;
            win_bad <= 1'b0;
            pll_locked <= 1'b0;
        end else begin
            phase_err <= lock_clear ? 8'sh00 : next_phase_err;
            if (lock_clear || (ref_tick && win_count == CCPC_LOCK_WINDOW)) begin
                win_count <= 6'h00;
                win_bad <= 1'b0;
            end else begin
                win_count <= win_count + (ref_tick ? 6'h01 : 6'h00);
                win_bad <= win_bad || (next_phase_err > CCPC_LOCK_TOL)
                    || (next_phase_err < -CCPC_LOCK_TOL);
            end
            // Set wins over clear so a lock seen on the clearing edge survives
            pll_locked <= lock_set || (pll_locked && !lock_clear);
        end
    end

    // ==========================================================
    // Core clock: selected source, divided, gated only while low
    ccpc_gate_t gate_state;
    logic core_clk;
    logic src_active;
    logic [1:0] div_active;
    logic [2:0] master_clock_output_pin_cnt;
    logic master_clock_output_pin;
    wire logic core_tick;
    wire logic src_edge;
    wire logic stop_req;
    wire logic [2:0] core_div;
    wire logic core_rise;
    wire logic master_clock_output_pin_sel;

    assign src_edge = src_active ? vco_any : mclk_any;
    assign core_div = {1'b0, div_active} + 3'h1;
    assign stop_req = !clock_setup.core_en || (src_active != clock_setup.src_pll)
        || (div_active != clock_setup.in_freq);
    assign core_rise = core_tick && !core_clk && (gate_state == CCPC_GATE_RUN) && !stop_req;

    ccpc_edge_div #(.W(3)) u_corediv (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .clear_in(gate_state == CCPC_GATE_OFF),
        .edge_in(src_edge),
        .div_in(core_div),
        .tick_out(core_tick)
    );

    // Settings change only while the clock is low, so no phase is ever cut short
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            gate_state <= CCPC_GATE_OFF;
            core_clk <= 1'b0;
            src_active <= 1'b0;
            div_active <= 2'h0;
        end else begin
            case (gate_state)
                CCPC_GATE_OFF: begin
                    src_active <= clock_setup.src_pll;
                    div_active <= clock_setup.in_freq;
                    if (clock_setup.core_en) begin
                        gate_state <= CCPC_GATE_RUN;
                    end
                end
                default: begin
                    if (stop_req && !core_clk) begin
                        gate_state <= CCPC_GATE_OFF;
                    end else if (core_tick) begin
                        core_clk <= !core_clk;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Microphone clock: binary fractions of the core clock
    assign master_clock_output_pin_sel = (clock_setup.master_clock_output_pin_freq == CCPC_MASTER_CLOCK_OUTPUT_PIN_32X) ? master_clock_output_pin_cnt[2]
        : (clock_setup.master_clock_output_pin_freq == CCPC_MASTER_CLOCK_OUTPUT_PIN_64X) ? master_clock_output_pin_cnt[1]
        : (clock_setup.master_clock_output_pin_freq == CCPC_MASTER_CLOCK_OUTPUT_PIN_128X) ? master_clock_output_pin_cnt[0] : core_clk;

    // Counter holds while the core clock stops, so a stop never cuts a mic phase short;
    // the pin drops on the same edge as the enable bit, never after it
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            master_clock_output_pin_cnt <= 3'h0;
            master_clock_output_pin <= 1'b0;
        end else begin
            master_clock_output_pin_cnt <= master_clock_output_pin_cnt + (core_rise ? 3'h1 : 3'h0);
            master_clock_output_pin <= master_clock_output_pin_sel && (wr_setup ? setup_written.master_clock_output_pin_en : clock_setup.master_clock_output_pin_en);
        end
    end

    // ==========================================================
    // Outputs
    assign cp_rdata_out = rdata;
    assign cp_rvalid_out = rvalid;
    assign sys_clock_out = core_clk;
    assign master_clock_output_pin_out = master_clock_output_pin;
    assign master_clock_output_pin_oe_out = clock_setup.master_clock_output_pin_en;
    assign core_supply_output_level_out = core_regulator_level.level;
    assign pll_enable_out = pll_en;
    assign pll_ref_tick_out = ref_tick;
    assign pll_fb_tick_out = fb_tick;

endmodule

// ==== tb/ccpc_clock_source.sv ====
`timescale 1ns/1ps
module ccpc_clock_source #(
    parameter int MCLK_HALF = 4,
    parameter int VCO_HALF = 3
) (
    input wire logic clk_in,
    output logic mclk_out,
    output logic vco_out
);
    // ==========================================================
    // Free-running reference and loop clocks
    int mc = 0;
    int vc = 0;
    initial begin
        mclk_out = 1'b0;
        vco_out = 1'b0;
    end
    // Steady rate well under the top limit, exact multiple of the frame rate
    always @(negedge clk_in) begin
        mc = (mc + 1) % MCLK_HALF;
        vc = (vc + 1) % VCO_HALF;
        if (mc == 0) begin
            mclk_out = ~mclk_out;
        end
        if (vc == 0) begin
            vco_out = ~vco_out;
        end
    end
endmodule

// ==== tb/ccpc_top_properties.sv ====
`timescale 1ns/1ps
module ccpc_checker import ccpc_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic cp_wr_in,
    input wire logic [15:0] cp_addr_in,
    input wire logic [7:0] cp_wdata_in,
    input wire logic sys_clock_out,
    input wire logic master_clock_output_pin_out,
    input wire logic master_clock_output_pin_oe_out,
    input wire logic [1:0] core_supply_output_level_out,
    input wire logic pll_enable_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    // ==========================================================
    // Shadow copies of the written fields
    logic [7:0] setup_q;
    logic [1:0] lvl_q;
    logic [6:0] off_cnt;
    wire wr_setup = cp_wr_in && (cp_addr_in == CCPC_ADDR_CLOCK_SETUP);
    wire wr_lvl = cp_wr_in && (cp_addr_in == CCPC_ADDR_LEVEL);
    wire wr_last = cp_wr_in && (cp_addr_in == 16'h4007);
    // Off counter saturates so a long stop stays visible
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            setup_q <= 8'h00;
            lvl_q <= CCPC_LEVEL_1V4;
            off_cnt <= 7'h00;
        end else begin
            if (wr_setup) setup_q <= cp_wdata_in;
            if (wr_lvl) lvl_q <= cp_wdata_in[2:1];
            off_cnt <= setup_q[0] ? 7'h00 : off_cnt + {6'h00, ~&off_cnt};
        end
    end
    // ==========================================================
    // Properties
    sequence s_lvl_write;
        wr_lvl ##1 !wr_lvl;
    endsequence
    sequence s_setup_write;
        wr_setup ##1 !wr_setup;
    endsequence
    property p_level_reset;
        $rose(rst_b_in) |-> core_supply_output_level_out == CCPC_LEVEL_1V4;
    endproperty
    property p_level_write;
        s_lvl_write |=> core_supply_output_level_out == lvl_q;
    endproperty
    property p_oe_write;
        s_setup_write |=> master_clock_output_pin_oe_out == setup_q[4];
    endproperty
    property p_pin_idle;
        !master_clock_output_pin_oe_out |-> !master_clock_output_pin_out;
    endproperty
    property p_mic_step;
        $changed(master_clock_output_pin_out) && master_clock_output_pin_oe_out
            && $past(master_clock_output_pin_oe_out, 2) && (setup_q[6:5] != 2'h3)
            && (setup_q[6:5] == $past(setup_q[6:5], 2))
            |-> $past(sys_clock_out) || $past(sys_clock_out, 2);
    endproperty
    property p_gate_off;
        off_cnt == 7'h7f |-> !sys_clock_out;
    endproperty
    property p_no_runt;
        $rose(sys_clock_out) |-> sys_clock_out [*2];
    endproperty
    property p_enable_commit;
        $changed(pll_enable_out) |-> $past(wr_last) || $past(wr_last, 2);
    endproperty
    a_level_reset: assert property (p_level_reset) else $error("level not 1.4 V");
    a_level_write: assert property (p_level_write) else $error("level mismatch");
    a_oe_write: assert property (p_oe_write) else $error("oe mismatch");
    a_pin_idle: assert property (p_pin_idle) else $error("pin active while off");
    a_mic_step: assert property (p_mic_step) else $error("mic clock off core edge");
    a_gate_off: assert property (p_gate_off) else $error("core clock runs gated");
    a_no_runt: assert property (p_no_runt) else $error("short core pulse");
    a_enable_commit: assert property (p_enable_commit) else $error("enable moved");
endmodule
bind ccpc_top ccpc_checker ccpc_checker_inst (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .cp_wr_in(cp_wr_in),
    .cp_addr_in(cp_addr_in),
    .cp_wdata_in(cp_wdata_in),
    .sys_clock_out(sys_clock_out),
    .master_clock_output_pin_out(master_clock_output_pin_out),
    .master_clock_output_pin_oe_out(master_clock_output_pin_oe_out),
    .core_supply_output_level_out(core_supply_output_level_out),
    .pll_enable_out(pll_enable_out)
);

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench import ccpc_pkg::*; ;
    // ==========================================================
    // Stimulus and observation
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic frame = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic [7:0] got;
    logic [7:0] bb [6];
    logic [1:0] sel = 2'h0;
    logic [1:0] lvl;
    logic [7:0] rdata;
    logic rvalid, mclk, vco, sys, pin, oe, pen, rtick, ftick;
    int bad_count = 0;
    int num_checks = 0;
    int cyc = 0;
    wire probe = (sel == 2'h0) ? sys : (sel == 2'h1) ? pin : (sel == 2'h2) ? rtick : ftick;
    ccpc_top ccpc_top_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .cp_frame_in(frame),
        .cp_wr_in(wr), .cp_rd_in(rd), .cp_addr_in(addr), .cp_wdata_in(wdata),
        .cp_rdata_out(rdata), .cp_rvalid_out(rvalid), .master_clock_input_pin_in(mclk),
        .pll_vco_in(vco), .sys_clock_out(sys), .master_clock_output_pin_out(pin),
        .master_clock_output_pin_oe_out(oe), .core_supply_output_level_out(lvl),
        .pll_enable_out(pen), .pll_ref_tick_out(rtick), .pll_fb_tick_out(ftick));
    ccpc_clock_source ccpc_clock_source_inst (.clk_in(clk_in), .mclk_out(mclk), .vco_out(vco));
    // Clock and hang guard; the whole run needs far fewer cycles than this
    always #10 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            $display("[FAIL] %0t timeout", $time);
            final_report();
        end
    end
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wrb(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_in);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk_in);
        wr = 1'b0;
    endtask
    // Answer is read one cycle after the read edge, when the strobe drops
    task automatic rdc(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
        @(negedge clk_in);
        rd = 1'b1;
        addr = a;
        @(negedge clk_in);
        rd = 1'b0;
        chk({7'h00, rvalid}, 8'h01);
        chk(rdata & m, e);
    endtask
    // Times the second to third edge: the first interval after a change may be stretched
    task automatic meas(input logic [1:0] s, input int e);
        int k, t0, n, hits;
        logic prev;
        sel = s;
        t0 = 0;
        n = 0;
        hits = 0;
        prev = probe;
        for (k = 0; k < 600 && hits < 3; k++) begin
            @(negedge clk_in);
            if (probe && !prev) begin
                hits++;
                n = k - t0;
                t0 = k;
            end
            prev = probe;
        end
        chk(8'(n), 8'(e));
    endtask
    task automatic burst(input int n);
        @(negedge clk_in);
        frame = 1'b1;
        for (int i = 0; i < n; i++) wrb(16'h4002 + 16'(i), bb[i]);
        @(negedge clk_in);
        frame = 1'b0;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        logic [7:0] rv [9] = '{8'h00, 8'h02, 8'h07, 8'h53, 8'h02, 8'h87, 8'h19, 8'h00, 8'h00};
        for (int i = 0; i < 9; i++) rdc(16'h4000 + 16'(i), 8'hff, rv[i]);
        chk({6'h00, lvl}, 8'h01);
        chk({6'h00, oe, pen}, 8'h00);
        chk({7'h00, sys}, 8'h00);
    endtask
    task automatic t_level();
        wrb(16'h4001, 8'hff);
        rdc(16'h4001, 8'hff, 8'h06);
        wrb(16'h4000, 8'h80);
        rdc(16'h4000, 8'hff, 8'h00);
        for (int i = 1; i < 5; i++) begin
            wrb(16'h4001, {5'h00, 2'(i), 1'b0});
            repeat (2) @(negedge clk_in);
            chk({6'h00, lvl}, {6'h00, 2'(i)});
        end
    endtask
    task automatic t_clocks();
        for (int d = 0; d < 4; d++) begin
            wrb(16'h4000, {5'h00, 2'(d), 1'b1});
            meas(2'h0, 8 * (d + 1));
        end
        wrb(16'h4000, 8'h0f);
        meas(2'h0, 24);
        for (int c = 0; c < 4; c++) begin
            wrb(16'h4000, {1'b0, 2'(c), 5'h11});
            meas(2'h1, 64 >> c);
            chk({7'h00, oe}, 8'h01);
        end
        wrb(16'h4000, 8'h00);
        repeat (80) @(negedge clk_in);
        chk({6'h00, oe, pin}, 8'h00);
        chk({7'h00, sys}, 8'h00);
    endtask
    task automatic t_synth();
        logic [7:0] div3 [4] = '{8'd8, 8'd16, 8'd16, 8'd24};
        for (int p = 0; p < 4; p++) begin
            bb = '{8'h00, 8'h7d, 8'h00, 8'h0c, 8'h21 | 8'(p << 1), 8'h01};
            burst(6);
            for (int i = 0; i < 6; i++) begin
                rdc(16'h4002 + 16'(i), (i == 5) ? 8'hfd : 8'hff, bb[i]);
            end
            chk({7'h00, pen}, 8'h01);
            meas(2'h2, div3[p]);
        end
        bb = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
        burst(5);
        rdc(16'h4002, 8'hff, 8'h00);
        wrb(16'h4007, 8'h00);
        chk({7'h00, pen}, 8'h01);
        bb = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00};
        burst(6);
        rdc(16'h4006, 8'hff, 8'h20);
        chk({7'h00, pen}, 8'h00);
        // Reference /3 and feedback /4 both tick every 24 cycles, so the loop must lock
        bb = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h26, 8'h01};
        burst(6);
        meas(2'h3, 24);
        repeat (1600) @(negedge clk_in);
        rdc(16'h4007, 8'hff, 8'h03);
        bb[5] = 8'h00;
        burst(6);
        rdc(16'h4007, 8'hff, 8'h00);
    endtask
    // ==========================================================
    // Verdict
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clk_in);
        rst_b_in = 1'b1;
        t_reset();
        t_level();
        t_clocks();
        t_synth();
        final_report();
    end
endmodule
